// ---- hdl/tap_access.sv ----
// file: test access path selector with quasi-random pattern generator and APB registers
//
// Operation
// [RULE_01] B-pair monitor: observe B, pass unchanged
// [RULE_02] split A: generator to F, E to detector
// [RULE_03] split B: generator to E, F to detector
// [RULE_04] full split E: detector, generator, filler, terminate
// [RULE_05] full split F: generator, detector, filler, terminate
// [RULE_06] split E loop F: loop F instead
// [RULE_07] split F loop E: loop E instead
// [RULE_08] loop E: detect and loop E, filler F
// [RULE_09] loop F: detect and loop F, filler E
// [RULE_10] pattern defaults quasi-random; 32-bit user pattern
// [RULE_11] 20 stages, feedback from 17 and 20
// [RULE_12] output from stage 20, not inverted
// [RULE_13] force one after fourteen following zeros
// [RULE_14] disable: no access, stop measurement, through-connect
// [RULE_15] A-pair monitor: observe A, pass unchanged
// [RULE_16] intrusive with internal code: unframed quasi-random
// [RULE_17] one mode; all switches change together (terminations move one edge before the registered line outputs)
// [RULE_18] generator seeded nonzero on reset, mode entry
//
// Register access over APB and the register addresses were chosen for this implementation.
module tap_access
  import tap_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // line bit clock enable, one cycle per bit
  input wire logic line_bit_en,
  // a transmission path: e to f
  input wire logic a_rx_e,
  output logic a_tx_f,
  // b transmission path: f to e
  input wire logic b_rx_f,
  output logic b_tx_e,
  // line terminations and monitor taps
  output logic term_e,
  output logic term_f,
  output logic monitor_bit,
  output logic monitor_valid,
  // measurement control
  output logic meas_run
);

  // ==========================================================================
  // input synchronisers: lines are asynchronous pins
  logic [2:0] a_sync_reg;
  logic [2:0] b_sync_reg;
  logic a_line_reg;
  logic b_line_reg;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      a_sync_reg <= 3'h0;
      b_sync_reg <= 3'h0;
    end else begin
      a_sync_reg <= {a_sync_reg[1:0], a_rx_e};
      b_sync_reg <= {b_sync_reg[1:0], b_rx_f};
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      a_line_reg <= 1'b0;
      b_line_reg <= 1'b0;
    end else begin
      if (a_sync_reg[1] == a_sync_reg[2]) begin
        a_line_reg <= a_sync_reg[2];
      end
      if (b_sync_reg[1] == b_sync_reg[2]) begin
        b_line_reg <= b_sync_reg[2];
      end
    end
  end

  // ==========================================================================
  // registers
  tap_mode_t mode_reg;
  tap_pat_t pat_reg;
  logic unframed_reg;
  logic int_code_reg;
  logic [31:0] user_reg;
  logic [TAP_ULEN_W-1:0] ulen_reg;
  logic meas_reg;
  logic mode_chg;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic intrusive;
  logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_level;
  logic fifo_out_valid;
  logic fifo_out_data;
  logic fifo_in_ready;

  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign addr_ok = (paddr == TAP_MODE_OFS) || (paddr == TAP_PAT_OFS) || (paddr == TAP_USER_OFS) ||
                   (paddr == TAP_ULEN_OFS) || (paddr == TAP_STAT_OFS) || (paddr == TAP_DETECT_OFS);
  assign pslverr = psel && penable && !addr_ok;
  assign intrusive = (mode_reg != TAP_DISABLE) && (mode_reg != TAP_MON_A) && (mode_reg != TAP_MON_B);
  // undefined encodings are ignored so only a legal mode is ever held
  assign mode_chg = wr_en && (paddr == TAP_MODE_OFS) && (pwdata[TAP_MODE_W-1:0] != mode_reg) &&
                    (tap_mode_t'(pwdata[TAP_MODE_W-1:0]) inside {TAP_DISABLE, TAP_MON_A, TAP_MON_B,
                     TAP_SPLIT_A, TAP_SPLIT_B, TAP_FULL_E, TAP_FULL_F, TAP_SPLIT_E_LOOP_F,
                     TAP_SPLIT_F_LOOP_E, TAP_LOOP_E, TAP_LOOP_F});

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mode_reg <= TAP_DISABLE;
    end else if (mode_chg) begin
      mode_reg <= tap_mode_t'(pwdata[TAP_MODE_W-1:0]); // see [RULE_17]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pat_reg <= TAP_PAT_QRS; // see [RULE_10]
      unframed_reg <= 1'b1;
      int_code_reg <= 1'b1;
    end else if (mode_chg && int_code_reg && (pwdata[TAP_MODE_W-1:0] inside {TAP_SPLIT_A, TAP_SPLIT_B,
                 TAP_FULL_E, TAP_FULL_F, TAP_SPLIT_E_LOOP_F, TAP_SPLIT_F_LOOP_E, TAP_LOOP_E, TAP_LOOP_F})) begin
      pat_reg <= TAP_PAT_QRS; // see [RULE_16]
      unframed_reg <= 1'b1;
    end else if (wr_en && (paddr == TAP_PAT_OFS)) begin
      pat_reg <= (pwdata[TAP_PAT_W-1:0] == TAP_PAT_ONES) ? TAP_PAT_ONES :
                 (pwdata[TAP_PAT_W-1:0] == TAP_PAT_USER) ? TAP_PAT_USER : TAP_PAT_QRS;
      unframed_reg <= pwdata[TAP_PAT_UNFRAMED_BIT];
      int_code_reg <= pwdata[TAP_PAT_INTCODE_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      user_reg <= TAP_USER_RST;
      ulen_reg <= TAP_ULEN_RST;
    end else if (wr_en && (paddr == TAP_USER_OFS)) begin
      user_reg <= pwdata; // see [RULE_10]
    end else if (wr_en && (paddr == TAP_ULEN_OFS)) begin
      ulen_reg <= pwdata[TAP_ULEN_W-1:0];
    end
  end

  // measurement runs only under an access mode
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meas_reg <= 1'b0;
    end else if (mode_chg && (pwdata[TAP_MODE_W-1:0] == TAP_DISABLE)) begin
      meas_reg <= 1'b0; // see [RULE_14]
    end else if (wr_en && (paddr == TAP_STAT_OFS)) begin
      meas_reg <= pwdata[TAP_STAT_MEAS_BIT] && (mode_reg != TAP_DISABLE);
    end
  end
  assign meas_run = meas_reg;

  // ==========================================================================
  // quasi-random generator, shared by test signal and filler
  logic [TAP_QRS_STAGES-1:0] qrs_reg;
  logic qrs_bit;
  logic [4:0] user_idx_reg;
  logic gen_bit;

  always_ff @(posedge sys_clk) begin
    if (reset || mode_chg) begin
      qrs_reg <= TAP_QRS_SEED; // see [RULE_18]
    end else if (line_bit_en) begin
      qrs_reg <= {qrs_reg[TAP_QRS_STAGES-2:0],
                  qrs_reg[TAP_QRS_TAP_A-1] ^ qrs_reg[TAP_QRS_TAP_B-1]}; // see [RULE_11]
    end
  end

  // stage 20 is the msb; the 14 bits after it sit just below
  assign qrs_bit = qrs_reg[TAP_QRS_STAGES-1] | // see [RULE_12]
                   (qrs_reg[TAP_QRS_STAGES-2 -: TAP_QRS_ZERO_RUN] == '0); // see [RULE_13]

  always_ff @(posedge sys_clk) begin
    if (reset || mode_chg) begin
      user_idx_reg <= 5'h00;
    end else if (line_bit_en) begin
      user_idx_reg <= (user_idx_reg == ulen_reg) ? 5'h00 : user_idx_reg + 5'h01;
    end
  end

  always_comb begin
    case (pat_reg)
      TAP_PAT_USER: gen_bit = user_reg[TAP_USER_MAX-1-user_idx_reg];
      TAP_PAT_ONES: gen_bit = 1'b1;
      default: gen_bit = qrs_bit;
    endcase
  end

  // ==========================================================================
  // path switch matrix: one decode of one mode register drives every switch
  logic a_out;
  logic b_out;
  logic det_bit;
  logic det_on;

  always_comb begin
    a_out = a_line_reg; // see [RULE_14]
    b_out = b_line_reg;
    det_bit = 1'b0;
    det_on = 1'b0;
    term_e = 1'b0;
    term_f = 1'b0;
    case (mode_reg) // see [RULE_17]
      TAP_MON_A: begin
        det_bit = a_line_reg; // see [RULE_15]
        det_on = 1'b1;
      end
      TAP_MON_B: begin
        det_bit = b_line_reg; // see [RULE_01]
        det_on = 1'b1;
      end
      TAP_SPLIT_A: begin
        a_out = gen_bit; // see [RULE_02]
        det_bit = a_line_reg;
        det_on = 1'b1;
      end
      TAP_SPLIT_B: begin
        b_out = gen_bit; // see [RULE_03]
        det_bit = b_line_reg;
        det_on = 1'b1;
      end
      TAP_FULL_E: begin
        b_out = gen_bit; // see [RULE_04]
        a_out = qrs_bit;
        det_bit = a_line_reg;
        det_on = 1'b1;
        term_f = 1'b1;
      end
      TAP_FULL_F: begin
        a_out = gen_bit; // see [RULE_05]
        b_out = qrs_bit;
        det_bit = b_line_reg;
        det_on = 1'b1;
        term_e = 1'b1;
      end
      TAP_SPLIT_E_LOOP_F: begin
        b_out = gen_bit; // see [RULE_06]
        a_out = b_line_reg;
        det_bit = a_line_reg;
        det_on = 1'b1;
      end
      TAP_SPLIT_F_LOOP_E: begin
        a_out = gen_bit; // see [RULE_07]
        b_out = a_line_reg;
        det_bit = b_line_reg;
        det_on = 1'b1;
      end
      TAP_LOOP_E: begin
        b_out = a_line_reg; // see [RULE_08]
        a_out = qrs_bit;
        det_bit = a_line_reg;
        det_on = 1'b1;
        term_f = 1'b1;
      end
      TAP_LOOP_F: begin
        a_out = b_line_reg; // see [RULE_09]
        b_out = qrs_bit;
        det_bit = b_line_reg;
        det_on = 1'b1;
        term_e = 1'b1;
      end
      default: begin
        det_on = 1'b0;
      end
    endcase
  end

  // registered line and monitor outputs move on the same edge; term_e and term_f follow mode_reg one edge sooner
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      a_tx_f <= 1'b0;
      b_tx_e <= 1'b0;
      monitor_bit <= 1'b0;
      monitor_valid <= 1'b0;
    end else begin
      a_tx_f <= a_out;
      b_tx_e <= b_out;
      monitor_bit <= det_bit;
      monitor_valid <= det_on && line_bit_en;
    end
  end

  // ==========================================================================
  // detected bits queue for software; full queue drops new bits
  logic fifo_pop;

  assign fifo_pop = rd_en && (paddr == TAP_DETECT_OFS);

  tap_fifo #(
    .WIDTH(1),
    .DEPTH(FIFO_DEPTH)
  ) u_det_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_valid(det_on && line_bit_en && meas_reg),
    .in_ready(fifo_in_ready),
    .in_data(det_bit),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // ==========================================================================
  // read mux
  always_comb begin
    prdata = 32'h00000000;
    case (paddr)
      TAP_MODE_OFS: prdata[TAP_MODE_W-1:0] = mode_reg;
      TAP_PAT_OFS: prdata[TAP_PAT_INTCODE_BIT:0] = {int_code_reg, unframed_reg, pat_reg};
      TAP_USER_OFS: prdata = user_reg;
      TAP_ULEN_OFS: prdata[TAP_ULEN_W-1:0] = ulen_reg;
      TAP_STAT_OFS: begin
        prdata[TAP_STAT_MEAS_BIT] = meas_reg;
        prdata[TAP_STAT_INTRUSIVE_BIT] = intrusive;
        prdata[TAP_STAT_MODE_LSB +: TAP_MODE_W] = mode_reg;
        prdata[TAP_STAT_FIFO_LSB +: 4] = 4'(fifo_level);
        prdata[TAP_STAT_FIFO_LSB + 4] = !fifo_in_ready;
      end
      TAP_DETECT_OFS: prdata[1:0] = {fifo_out_valid, fifo_out_data};
      default: prdata = 32'h00000000;
    endcase
  end

endmodule // tap_access

// ---- hdl/tap_pkg.sv ----
// package: register map, field layout, mode and pattern encodings for the test access path
package tap_pkg;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [11:0] TAP_MODE_OFS = 12'h000;
  localparam logic [11:0] TAP_PAT_OFS = 12'h004;
  localparam logic [11:0] TAP_USER_OFS = 12'h008;
  localparam logic [11:0] TAP_ULEN_OFS = 12'h00C;
  localparam logic [11:0] TAP_STAT_OFS = 12'h010;
  localparam logic [11:0] TAP_TXDATA_OFS = 12'h014;
  localparam logic [11:0] TAP_DETECT_OFS = 12'h018;

  // ==========================================================================
  // field positions and widths
  localparam int TAP_MODE_W = 4;
  localparam int TAP_PAT_W = 2;
  localparam int TAP_ULEN_W = 5;
  localparam int TAP_PAT_UNFRAMED_BIT = 2;
  localparam int TAP_PAT_INTCODE_BIT = 3;
  localparam int TAP_STAT_MEAS_BIT = 0;
  localparam int TAP_STAT_INTRUSIVE_BIT = 1;
  localparam int TAP_STAT_MODE_LSB = 4;
  localparam int TAP_STAT_FIFO_LSB = 8;

  // ==========================================================================
  // quasi-random generator layout
  localparam int TAP_QRS_STAGES = 20;
  localparam int TAP_QRS_TAP_A = 17;
  localparam int TAP_QRS_TAP_B = 20;
  localparam int TAP_QRS_ZERO_RUN = 14;
  localparam logic [19:0] TAP_QRS_SEED = 20'hFFFFF;
  localparam int TAP_USER_MAX = 32;

  // ==========================================================================
  // reset values
  localparam logic [31:0] TAP_USER_RST = 32'h00000000;
  localparam logic [4:0] TAP_ULEN_RST = 5'h1F;

  // ==========================================================================
  // access modes, gray coded along the menu order
  typedef enum logic [3:0] {
    TAP_DISABLE = 4'h0,
    TAP_MON_A = 4'h1,
    TAP_MON_B = 4'h3,
    TAP_SPLIT_A = 4'h2,
    TAP_SPLIT_B = 4'h6,
    TAP_FULL_E = 4'h7,
    TAP_FULL_F = 4'h5,
    TAP_SPLIT_E_LOOP_F = 4'h4,
    TAP_SPLIT_F_LOOP_E = 4'hC,
    TAP_LOOP_E = 4'hD,
    TAP_LOOP_F = 4'hF
  } tap_mode_t;

  // generator pattern selection
  typedef enum logic [1:0] {
    TAP_PAT_QRS = 2'h0,
    TAP_PAT_USER = 2'h1,
    TAP_PAT_ONES = 2'h3
  } tap_pat_t;

endpackage : tap_pkg

// ---- hdl/tap_fifo.sv ----
// file: parameterised valid/ready FIFO held in flip-flops
module tap_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // occupancy
  output logic [$clog2(DEPTH+1)-1:0] level
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [$clog2(DEPTH+1)-1:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid = (count_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_reg[rd_ptr_reg];
  assign level = count_reg;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      case ({push, pop})
        2'b10: count_reg <= count_reg + 1'b1;
        2'b01: count_reg <= count_reg - 1'b1;
        default: count_reg <= count_reg;
      endcase
    end
  end

endmodule // tap_fifo

// ---- bench/tap_access_monitor.sv ----
// checker: concurrent assertions on the test access path ports
module tap_access_monitor
  import tap_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  // lines
  input wire logic a_rx_e,
  input wire logic a_tx_f,
  input wire logic b_rx_f,
  input wire logic b_tx_e,
  input wire logic term_e,
  input wire logic term_f,
  input wire logic monitor_valid,
  input wire logic meas_run
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ====================
  // mode shadow
  logic mode_wr;
  logic [3:0] mode_reg;
  logic [3:0] settle_reg;
  logic settled;
  logic thru;
  assign mode_wr = psel && penable && pwrite && paddr == TAP_MODE_OFS
    && !(pwdata[3:0] inside {4'h8, 4'h9, 4'hA, 4'hB, 4'hE});
  assign thru = mode_reg inside {TAP_DISABLE, TAP_MON_A, TAP_MON_B};
  // six cycles covers the three-flop sync, the line register and the output stage
  assign settled = settle_reg >= 4'h6;
  always_ff @(posedge sys_clk) begin
    if (reset) mode_reg <= TAP_DISABLE;
    else if (mode_wr) mode_reg <= pwdata[3:0];
  end
  always_ff @(posedge sys_clk) begin
    if (reset || mode_wr) settle_reg <= 4'h0;
    else if (settle_reg != 4'hF) settle_reg <= settle_reg + 4'h1;
  end
  // ====================
  // assertions
  AST_THRU_A: assert property (settled && thru |-> a_tx_f == $past(a_rx_e, 5))
    else $error("a path not passed through");
  AST_THRU_B: assert property (settled && thru |-> b_tx_e == $past(b_rx_f, 5))
    else $error("b path not passed through");
  AST_NO_TERM: assert property (settle_reg != 4'h0 && thru |-> !term_e && !term_f)
    else $error("termination in non-intrusive mode");
  AST_MEAS_STOP: assert property (mode_wr && pwdata[3:0] == TAP_DISABLE |=> !meas_run [*3])
    else $error("measurement not stopped");
  AST_NO_MON: assert property (settled && mode_reg == TAP_DISABLE |-> !monitor_valid)
    else $error("monitor access while disabled");
  AST_LOOP_E_TERM: assert property (mode_wr && pwdata[3:0] == TAP_LOOP_E |=> term_f && !term_e)
    else $error("loop e termination wrong");
  AST_LOOP_F_TERM: assert property (mode_wr && pwdata[3:0] == TAP_LOOP_F |=> term_e && !term_f)
    else $error("loop f termination wrong");
  AST_LOOP_E_DATA: assert property (settled && mode_reg == TAP_LOOP_E |-> b_tx_e == $past(a_rx_e, 5))
    else $error("loop e data not looped");
  AST_LOOP_F_DATA: assert property (settled && mode_reg == TAP_LOOP_F |-> a_tx_f == $past(b_rx_f, 5))
    else $error("loop f data not looped");
  // ====================
  // covers
  COV_LOOP_E: cover property (settled && mode_reg == TAP_LOOP_E);
  COV_LOOP_F: cover property (settled && mode_reg == TAP_LOOP_F);
  COV_ERR: cover property (psel && penable && pslverr);
endmodule // tap_access_monitor

// ---- bench/tap_span_model.sv ----
// model of the two span lines arriving from e and f
module tap_span_model (
  // clock
  input wire logic sys_clk,
  // levels commanded by the bench
  input wire logic a_lvl,
  input wire logic b_lvl,
  // line pins
  output logic a_rx_e,
  output logic b_rx_f
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    a_rx_e = 1'b0;
    b_rx_f = 1'b0;
  end
  // lines change just after the edge, like a real retimed span
  always @(posedge sys_clk) begin
    a_rx_e <= a_lvl;
    b_rx_f <= b_lvl;
  end
endmodule // tap_span_model

// ---- bench/tap_access_tb.sv ----
// testbench: routing, generator and measurement checks of the access path
module tap_access_tb
  import tap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic line_bit_en = 1'b0, a_lvl = 1'b0, b_lvl = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic pready, pslverr, a_rx_e, a_tx_f, b_rx_f, b_tx_e, term_e, term_f, monitor_bit, monitor_valid, meas_run;
  int fail_count = 0, n_tests = 0, cyc = 0;
  // mode, a_tx_f code, b_tx_e code, detector code (0 a, 1 b, 2 gen, 3 filler, F none)
  logic [15:0] tbl [11] = '{16'h001F, 16'h1010, 16'h3011, 16'h2210, 16'h6021, 16'h7320,
    16'h5231, 16'h4120, 16'hC201, 16'hD300, 16'hF131};
  always #10 sys_clk = ~sys_clk;
  tap_access dut (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .line_bit_en, .a_rx_e, .a_tx_f, .b_rx_f, .b_tx_e, .term_e, .term_f, .monitor_bit, .monitor_valid, .meas_run);
  tap_span_model span (.sys_clk, .a_lvl, .b_lvl, .a_rx_e, .b_rx_f);
  // ====================
  // helpers
  task finish_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(nm, rd, exp);
  endtask
  // settle the sync first so the detector sees the new level
  task bit_pulse();
    repeat (6) @(posedge sys_clk);
    line_bit_en <= 1'b1;
    @(posedge sys_clk);
    line_bit_en <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask
  function logic [31:0] lv(input logic [3:0] c, input logic a);
    case (c)
      4'h0: lv = {31'h0, a};
      4'h1: lv = {31'h0, !a};
      4'h2: lv = 32'h00000000;
      default: lv = 32'h00000001;
    endcase
  endfunction
  // ====================
  // scenarios
  task t_reset_vals();
    rdc("mode", TAP_MODE_OFS, 32'h00000000);
    rdc("pat", TAP_PAT_OFS, 32'h0000000C);
    rdc("user", TAP_USER_OFS, 32'h00000000);
    rdc("ulen", TAP_ULEN_OFS, 32'h0000001F);
    rdc("stat", TAP_STAT_OFS, 32'h00000000);
  endtask
  task t_refuse();
    wr(TAP_TXDATA_OFS, 32'h00000001);
    check("wr err", {31'h0, err}, 32'h00000001);
    rdc("unmapped", TAP_TXDATA_OFS, 32'h00000000);
    check("rd err", {31'h0, err}, 32'h00000001);
    wr(TAP_MODE_OFS, 32'h00000008);
    rdc("bad mode", TAP_MODE_OFS, 32'h00000000);
  endtask
  task t_routes();
    logic [15:0] e;
    // user pattern of zeros tells the generator apart from the filler
    wr(TAP_PAT_OFS, 32'h00000001);
    for (int i = 0; i < 11; i++) begin
      e = tbl[i];
      wr(TAP_MODE_OFS, {28'h0, e[15:12]});
      for (int j = 0; j < 2; j++) begin
        a_lvl <= j[0];
        b_lvl <= !j[0];
        bit_pulse();
        check("a_tx_f", {31'h0, a_tx_f}, lv(e[11:8], j[0]));
        check("b_tx_e", {31'h0, b_tx_e}, lv(e[7:4], j[0]));
        if (e[3:0] != 4'hF) check("monitor_bit", {31'h0, monitor_bit}, lv(e[3:0], j[0]));
      end
      if (e[15:12] inside {4'h7, 4'hD}) check("term", {30'h0, term_e, term_f}, 32'h00000001);
      else if (e[15:12] inside {4'h5, 4'hF}) check("term", {30'h0, term_e, term_f}, 32'h00000002);
      else if (e[15:12] inside {4'h0, 4'h1, 4'h3}) check("term", {30'h0, term_e, term_f}, 32'h00000000);
    end
  endtask
  task t_qrs();
    logic [20:1] s;
    wr(TAP_PAT_OFS, 32'h0000000B);
    wr(TAP_MODE_OFS, {28'h0, TAP_SPLIT_A});
    rdc("pat forced", TAP_PAT_OFS, 32'h0000000C);
    s = TAP_QRS_SEED;
    for (int k = 0; k < 1500; k++) begin
      repeat (4) @(posedge sys_clk);
      check("qrs", {31'h0, a_tx_f}, {31'h0, s[20] | (s[19:6] == 14'h0000)});
      line_bit_en <= 1'b1;
      @(posedge sys_clk);
      line_bit_en <= 1'b0;
      s = {s[19:1], s[17] ^ s[20]};
    end
  endtask
  task t_fifo();
    wr(TAP_MODE_OFS, {28'h0, TAP_LOOP_E});
    a_lvl <= 1'b1;
    wr(TAP_STAT_OFS, 32'h00000001);
    // the register moves on the access edge, so look one edge later
    @(posedge sys_clk);
    check("meas on", {31'h0, meas_run}, 32'h00000001);
    // ten bits into eight places: the last two must be dropped
    repeat (10) bit_pulse();
    rdc("stat full", TAP_STAT_OFS, 32'h000018D3);
    repeat (8) rdc("detect", TAP_DETECT_OFS, 32'h00000003);
    apb(1'b0, TAP_DETECT_OFS, 32'h00000000);
    check("empty", {31'h0, rd[1]}, 32'h00000000);
    wr(TAP_MODE_OFS, {28'h0, TAP_DISABLE});
    @(posedge sys_clk);
    check("meas off", {31'h0, meas_run}, 32'h00000000);
    wr(TAP_STAT_OFS, 32'h00000001);
    rdc("stat idle", TAP_STAT_OFS, 32'h00000000);
  endtask
  task t_user();
    logic [31:0] u;
    // four-bit word 0101, sent msb first, then all ones
    u = 32'h50000000;
    wr(TAP_PAT_OFS, 32'h00000001);
    wr(TAP_USER_OFS, u);
    wr(TAP_ULEN_OFS, 32'h00000003);
    wr(TAP_MODE_OFS, {28'h0, TAP_SPLIT_A});
    for (int k = 0; k < 8; k++) begin
      repeat (4) @(posedge sys_clk);
      check("user", {31'h0, a_tx_f}, {31'h0, u[31 - (k % 4)]});
      line_bit_en <= 1'b1;
      @(posedge sys_clk);
      line_bit_en <= 1'b0;
    end
    wr(TAP_PAT_OFS, 32'h00000003);
    repeat (2) @(posedge sys_clk);
    check("ones", {31'h0, a_tx_f}, 32'h00000001);
  endtask
  // ====================
  // sequence and timeout
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset_vals();
    t_refuse();
    t_routes();
    t_qrs();
    t_fifo();
    t_user();
    finish_test();
  end
endmodule // tap_access_tb

bind tap_access tap_access_monitor mon (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
  .a_rx_e, .a_tx_f, .b_rx_f, .b_tx_e, .term_e, .term_f, .monitor_valid, .meas_run);
